// file: verilog/psq_defines.svh
// Constants for the status query engine: field positions, ASCII codes and lengths.
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH

// Operational flag positions (bit 1 of the image sits at index 0).
`define PSQ_OP_REGMODE 0
`define PSQ_OP_FOLD_ARMED 1
`define PSQ_OP_AUTO_RESTART 2
`define PSQ_OP_OUTPUT_ON 3
`define PSQ_OP_SRQ_FOLD 4
`define PSQ_OP_SRQ_OVP 5
`define PSQ_OP_SRQ_OTP 6
`define PSQ_OP_ALARM_SUM 7
`define PSQ_OP_W 8

// Fault latch positions.
`define PSQ_AL_OVERVOLT 0
`define PSQ_AL_THERMAL 1
`define PSQ_AL_INPUT_FAIL 2
`define PSQ_AL_FOLDBACK 3
`define PSQ_AL_CMD_FAULT 4
`define PSQ_AL_W 5

// Command error positions; index 0 is unused and reads zero.
`define PSQ_ER_UNUSED 0
`define PSQ_ER_UNKNOWN 1
`define PSQ_ER_OVERFLOW 2
`define PSQ_ER_VOLT_RANGE 3
`define PSQ_ER_CURR_RANGE 4
`define PSQ_ER_W 5

// Reply segment indices in complete-status order.
`define PSQ_SEG_ACT_VOLT 3'h0
`define PSQ_SEG_SET_VOLT 3'h1
`define PSQ_SEG_ACT_CURR 3'h2
`define PSQ_SEG_SET_CURR 3'h3
`define PSQ_SEG_OPER 3'h4
`define PSQ_SEG_ALARM 3'h5
`define PSQ_SEG_ERROR 3'h6
`define PSQ_SEG_COUNT 7

// Two-letter prefixes, first letter in the upper byte.
`define PSQ_PFX_ACT_VOLT 16'h4156
`define PSQ_PFX_SET_VOLT 16'h5356
`define PSQ_PFX_ACT_CURR 16'h4141
`define PSQ_PFX_SET_CURR 16'h5341
`define PSQ_PFX_OPER 16'h4F53
`define PSQ_PFX_ALARM 16'h414C
`define PSQ_PFX_ERROR 16'h5053

// ASCII characters.
`define PSQ_CHR_ZERO 8'h30
`define PSQ_CHR_ONE 8'h31
`define PSQ_CHR_CR 8'h0D
`define PSQ_CHR_LF 8'h0A

// Default width of each numeric field in characters.
`define PSQ_ANA_CHARS 5
// Nominal command processing time that the host allows for.
`define PSQ_CMD_PROC_MS 15

`endif

// file: verilog/psq_pkg.sv
// Types shared by the status query engine.
package psq_pkg;

   typedef enum logic [2:0] {
      PSQ_CMD_OTHER = 3'h0,
      PSQ_CMD_CLEAR = 3'h1,
      PSQ_CMD_OPER_Q = 3'h2,
      PSQ_CMD_ALARM_Q = 3'h3,
      PSQ_CMD_ERROR_Q = 3'h4,
      PSQ_CMD_FULL_Q = 3'h5,
      PSQ_CMD_ADDR_SEL = 3'h6
   } psq_cmd_t;

   typedef enum logic [4:0] {
      PSQ_ST_IDLE = 5'h01,
      PSQ_ST_PREFIX = 5'h02,
      PSQ_ST_BODY = 5'h04,
      PSQ_ST_CR = 5'h08,
      PSQ_ST_LF = 5'h10
   } psq_state_t;

endpackage : psq_pkg

// file: verilog/psq_bit_image.sv
// Turns a flag vector into one ASCII digit per bit, selected by character index.
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"

module psq_bit_image #(
   parameter int W = 8
) (
   // Flags and selection.
   input wire logic [W-1:0] i_bits,
   input wire logic [3:0] i_idx,
   // Selected character.
   output logic [7:0] o_char
);

   logic [7:0] chars [0:15];

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_chr
         if (g < W) begin : g_used
            assign chars[g] = i_bits[g] ? `PSQ_CHR_ONE : `PSQ_CHR_ZERO; // [R22]
         end else begin : g_pad
            assign chars[g] = `PSQ_CHR_ZERO;
         end
      end
   endgenerate

   assign o_char = chars[i_idx];

endmodule : psq_bit_image
`default_nettype wire

// file: verilog/psq_status_engine.sv
// Status registers, unit addressing and ASCII reply generation of the remote interface.
//
// Function
// [R01] Operational flags update every cycle; reads never change them; clear empties summary.
// [R02] Operational bit 1 reports regulation mode: 0 voltage, 1 current.
// [R03] Bits 2-4 report foldback armed, auto-restart on and output on.
// [R04] Bits 5-7 report service request enables for foldback, over-voltage, over-temperature.
// [R05] Bit 8 is set whenever any fault latch bit except input failure is set.
// [R06] The input supply failure bit never sets the operational alarm summary.
// [R07] Fault latch holds over-voltage, thermal, input fail, foldback, command fault.
// [R08] Over-voltage, thermal and command fault clear at power-off or clear command.
// [R09] Foldback fault bit clears itself when foldback protection is cancelled.
// [R10] Input failure sets at every power-off; host clears it after power-up.
// [R11] Any error bit forces command fault; errors clear only by clear command.
// [R12] Error bits: unused, unknown command, overflow, voltage range, current range.
// [R13] Operational query replies with its prefix and one digit per bit.
// [R14] Alarm query replies with its prefix and the fault latch digits.
// [R15] Error query replies with its prefix and the error digits.
// [R16] Complete query sends seven prefixed fields in the fixed documented order.
// [R17] Host allows a nominal fifteen millisecond processing time per command.
// [R18] Host waits for a reply to finish before sending the next command.
// [R19] Unit starts listening; only an address match makes it active.
// [R20] Another unit's address sends this unit back to listen mode.
// [R21] Every reply ends with carriage return then line feed.
// [R22] Image digits are ASCII 0 or 1, bit 1 first, ascending.
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"

module psq_status_engine
   import psq_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int ANA_CHARS = `PSQ_ANA_CHARS
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Unit address strap, asynchronous to the clock.
   input wire logic [ADDR_W-1:0] i_unit_addr,
   // Decoded command from the serial parser.
   input wire logic i_cmd_valid,
   input wire psq_cmd_t i_cmd_code,
   input wire logic [ADDR_W-1:0] i_cmd_addr,
   // Live supply state.
   input wire logic i_regulation_mode,
   input wire logic i_fold_armed,
   input wire logic i_auto_restart,
   input wire logic i_output_on,
   input wire logic i_srq_fold_en,
   input wire logic i_srq_ovp_en,
   input wire logic i_srq_otp_en,
   // Fault events, one-cycle pulses.
   input wire logic i_ovp_trip,
   input wire logic i_otp_trip,
   input wire logic i_ac_off,
   input wire logic i_fold_trip,
   input wire logic i_fold_cancel,
   // Command error events, one-cycle pulses.
   input wire logic i_err_unknown,
   input wire logic i_err_overflow,
   input wire logic i_err_volt_range,
   input wire logic i_err_curr_range,
   // Numeric fields as ASCII, first character in the top byte.
   input wire logic [8*ANA_CHARS-1:0] i_act_volt,
   input wire logic [8*ANA_CHARS-1:0] i_set_volt,
   input wire logic [8*ANA_CHARS-1:0] i_act_curr,
   input wire logic [8*ANA_CHARS-1:0] i_set_curr,
   // Reply character stream.
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   // Status views.
   output logic o_unit_active,
   output logic o_busy,
   output logic [`PSQ_OP_W-1:0] o_op_flags,
   output logic [`PSQ_AL_W-1:0] o_alarm_flags,
   output logic [`PSQ_ER_W-1:0] o_error_flags
);

   // Address strap synchroniser.
   logic [ADDR_W-1:0] addr_meta_ff;
   logic [ADDR_W-1:0] addr_sync_ff;

   // Status registers.
   logic [`PSQ_OP_W-1:0] op_ff;
   logic [`PSQ_AL_W-1:0] alm_ff;
   logic [`PSQ_ER_W-1:0] err_ff;
   logic active_ff;

   // Reply snapshots, so a slow drain cannot tear the image.
   logic [`PSQ_OP_W-1:0] snap_op_ff;
   logic [`PSQ_AL_W-1:0] snap_alm_ff;
   logic [`PSQ_ER_W-1:0] snap_err_ff;
   logic [8*ANA_CHARS-1:0] snap_av_ff;
   logic [8*ANA_CHARS-1:0] snap_sv_ff;
   logic [8*ANA_CHARS-1:0] snap_aa_ff;
   logic [8*ANA_CHARS-1:0] snap_sa_ff;

   // Reply sequencer.
   psq_state_t state_ff;
   psq_state_t nxt_state;
   logic [2:0] seg_ff;
   logic [2:0] nxt_seg;
   logic [2:0] seg_end_ff;
   logic [3:0] chr_ff;
   logic [3:0] nxt_chr;
   logic tx_valid_ff;
   logic [7:0] tx_data_ff;
   logic [7:0] nxt_char;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         addr_meta_ff <= '0;
         addr_sync_ff <= '0;
      end else begin
         addr_meta_ff <= i_unit_addr;
         addr_sync_ff <= addr_meta_ff;
      end
   end

   // Command acceptance.
   wire is_query = (i_cmd_code == PSQ_CMD_OPER_Q) || (i_cmd_code == PSQ_CMD_ALARM_Q) ||
                   (i_cmd_code == PSQ_CMD_ERROR_Q) || (i_cmd_code == PSQ_CMD_FULL_Q);
   wire addr_cmd = i_cmd_valid && (i_cmd_code == PSQ_CMD_ADDR_SEL);
   wire addr_match = (i_cmd_addr == addr_sync_ff);
   wire clear_cmd = i_cmd_valid && active_ff && (i_cmd_code == PSQ_CMD_CLEAR); // [R19]
   // A query that lands while a reply is still going out is dropped.
   wire query_go = i_cmd_valid && active_ff && is_query && !o_busy; // [R18] [R19]

   // Start and end segment for each query.
   wire [2:0] q_seg_start = (i_cmd_code == PSQ_CMD_OPER_Q) ? `PSQ_SEG_OPER : // [R13]
                            (i_cmd_code == PSQ_CMD_ALARM_Q) ? `PSQ_SEG_ALARM : // [R14]
                            (i_cmd_code == PSQ_CMD_ERROR_Q) ? `PSQ_SEG_ERROR : // [R15]
                            `PSQ_SEG_ACT_VOLT; // [R16]
   wire [2:0] q_seg_end = (i_cmd_code == PSQ_CMD_FULL_Q) ? `PSQ_SEG_ERROR : q_seg_start; // [R16]

   // Error register; a new error beats a clear in the same cycle.
   logic [`PSQ_ER_W-1:0] err_set;
   assign err_set[`PSQ_ER_UNUSED] = 1'b0; // [R12]
   assign err_set[`PSQ_ER_UNKNOWN] = i_err_unknown; // [R12]
   assign err_set[`PSQ_ER_OVERFLOW] = i_err_overflow; // [R12]
   assign err_set[`PSQ_ER_VOLT_RANGE] = i_err_volt_range; // [R12]
   assign err_set[`PSQ_ER_CURR_RANGE] = i_err_curr_range; // [R12]
   wire [`PSQ_ER_W-1:0] nxt_err = (clear_cmd ? '0 : err_ff) | err_set; // [R11]

   // Fault latch next values.
   logic [`PSQ_AL_W-1:0] nxt_alm;
   wire clr_or_off = clear_cmd || i_ac_off;
   assign nxt_alm[`PSQ_AL_OVERVOLT] =
      (clr_or_off ? 1'b0 : alm_ff[`PSQ_AL_OVERVOLT]) | i_ovp_trip; // [R07] [R08]
   assign nxt_alm[`PSQ_AL_THERMAL] =
      (clr_or_off ? 1'b0 : alm_ff[`PSQ_AL_THERMAL]) | i_otp_trip; // [R07] [R08]
   assign nxt_alm[`PSQ_AL_INPUT_FAIL] =
      (clear_cmd ? 1'b0 : alm_ff[`PSQ_AL_INPUT_FAIL]) | i_ac_off; // [R10]
   assign nxt_alm[`PSQ_AL_FOLDBACK] =
      ((clear_cmd || i_fold_cancel) ? 1'b0 : alm_ff[`PSQ_AL_FOLDBACK]) | i_fold_trip; // [R09]
   assign nxt_alm[`PSQ_AL_CMD_FAULT] =
      (clr_or_off ? 1'b0 : alm_ff[`PSQ_AL_CMD_FAULT]) | (|nxt_err); // [R08] [R11]

   // Summary ignores the input failure bit.
   logic [`PSQ_AL_W-1:0] sum_mask;
   assign sum_mask = ~(`PSQ_AL_W'(1) << `PSQ_AL_INPUT_FAIL);
   wire alarm_sum = |(alm_ff & sum_mask); // [R05] [R06]

   logic [`PSQ_OP_W-1:0] nxt_op;
   assign nxt_op[`PSQ_OP_REGMODE] = i_regulation_mode; // [R02]
   assign nxt_op[`PSQ_OP_FOLD_ARMED] = i_fold_armed; // [R03]
   assign nxt_op[`PSQ_OP_AUTO_RESTART] = i_auto_restart; // [R03]
   assign nxt_op[`PSQ_OP_OUTPUT_ON] = i_output_on; // [R03]
   assign nxt_op[`PSQ_OP_SRQ_FOLD] = i_srq_fold_en; // [R04]
   assign nxt_op[`PSQ_OP_SRQ_OVP] = i_srq_ovp_en; // [R04]
   assign nxt_op[`PSQ_OP_SRQ_OTP] = i_srq_otp_en; // [R04]
   assign nxt_op[`PSQ_OP_ALARM_SUM] = alarm_sum; // [R05]

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         op_ff <= '0;
         alm_ff <= '0;
         err_ff <= '0;
      end else begin
         op_ff <= nxt_op; // [R01]
         alm_ff <= nxt_alm;
         err_ff <= nxt_err;
      end
   end

   // Addressing: listen after reset, active only on a matching select.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         active_ff <= 1'b0; // [R19]
      end else if (addr_cmd) begin
         active_ff <= addr_match; // [R19] [R20]
      end
   end

   // Snapshots are taken when a query is accepted.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         snap_op_ff <= '0;
         snap_alm_ff <= '0;
         snap_err_ff <= '0;
         snap_av_ff <= '0;
         snap_sv_ff <= '0;
         snap_aa_ff <= '0;
         snap_sa_ff <= '0;
      end else if (query_go) begin
         snap_op_ff <= op_ff; // [R01]
         snap_alm_ff <= alm_ff;
         snap_err_ff <= err_ff;
         snap_av_ff <= i_act_volt;
         snap_sv_ff <= i_set_volt;
         snap_aa_ff <= i_act_curr;
         snap_sa_ff <= i_set_curr;
      end
   end

   // Per-segment prefix and body length.
   wire [15:0] pfx_word = (seg_ff == `PSQ_SEG_ACT_VOLT) ? `PSQ_PFX_ACT_VOLT :
                          (seg_ff == `PSQ_SEG_SET_VOLT) ? `PSQ_PFX_SET_VOLT :
                          (seg_ff == `PSQ_SEG_ACT_CURR) ? `PSQ_PFX_ACT_CURR :
                          (seg_ff == `PSQ_SEG_SET_CURR) ? `PSQ_PFX_SET_CURR :
                          (seg_ff == `PSQ_SEG_OPER) ? `PSQ_PFX_OPER :
                          (seg_ff == `PSQ_SEG_ALARM) ? `PSQ_PFX_ALARM : `PSQ_PFX_ERROR;
   wire [7:0] pfx_char = chr_ff[0] ? pfx_word[7:0] : pfx_word[15:8];
   wire [3:0] body_last = (seg_ff == `PSQ_SEG_OPER) ? 4'(`PSQ_OP_W - 1) :
                          (seg_ff == `PSQ_SEG_ALARM) ? 4'(`PSQ_AL_W - 1) :
                          (seg_ff == `PSQ_SEG_ERROR) ? 4'(`PSQ_ER_W - 1) :
                          4'(ANA_CHARS - 1);

   // Numeric field character: shift the chosen string left so the wanted byte is on top.
   wire [8*ANA_CHARS-1:0] ana_sel = (seg_ff == `PSQ_SEG_ACT_VOLT) ? snap_av_ff :
                                    (seg_ff == `PSQ_SEG_SET_VOLT) ? snap_sv_ff :
                                    (seg_ff == `PSQ_SEG_ACT_CURR) ? snap_aa_ff : snap_sa_ff;
   wire [8*ANA_CHARS-1:0] ana_shift = ana_sel << {chr_ff, 3'h0};
   wire [7:0] ana_char = ana_shift[8*ANA_CHARS-1 -: 8];

   logic [7:0] op_char;
   logic [7:0] alm_char;
   logic [7:0] err_char;

   psq_bit_image #(.W(`PSQ_OP_W)) u_op_image (
      .i_bits(snap_op_ff),
      .i_idx(chr_ff),
      .o_char(op_char)
   );

   psq_bit_image #(.W(`PSQ_AL_W)) u_alm_image (
      .i_bits(snap_alm_ff),
      .i_idx(chr_ff),
      .o_char(alm_char)
   );

   psq_bit_image #(.W(`PSQ_ER_W)) u_err_image (
      .i_bits(snap_err_ff),
      .i_idx(chr_ff),
      .o_char(err_char)
   );

   wire [7:0] body_char = (seg_ff == `PSQ_SEG_OPER) ? op_char : // [R13]
                          (seg_ff == `PSQ_SEG_ALARM) ? alm_char : // [R14]
                          (seg_ff == `PSQ_SEG_ERROR) ? err_char : ana_char; // [R15] [R16]

   // The output stage takes a new character when it is empty or being drained.
   wire stage_free = !tx_valid_ff || i_tx_ready;
   wire step = (state_ff != PSQ_ST_IDLE) && stage_free;

   always_comb begin
      nxt_state = state_ff;
      nxt_seg = seg_ff;
      nxt_chr = chr_ff;
      nxt_char = tx_data_ff;
      case (state_ff)
         PSQ_ST_IDLE: begin
            if (query_go) begin
               nxt_state = PSQ_ST_PREFIX;
               nxt_seg = q_seg_start;
               nxt_chr = 4'h0;
            end
         end
         PSQ_ST_PREFIX: begin
            nxt_char = pfx_char;
            if (chr_ff[0]) begin
               nxt_state = PSQ_ST_BODY;
               nxt_chr = 4'h0;
            end else begin
               nxt_chr = chr_ff + 4'h1;
            end
         end
         PSQ_ST_BODY: begin
            nxt_char = body_char;
            if (chr_ff == body_last) begin
               nxt_chr = 4'h0;
               if (seg_ff == seg_end_ff) begin
                  nxt_state = PSQ_ST_CR; // [R21]
               end else begin
                  nxt_state = PSQ_ST_PREFIX; // [R16]
                  nxt_seg = seg_ff + 3'h1;
               end
            end else begin
               nxt_chr = chr_ff + 4'h1; // [R22]
            end
         end
         PSQ_ST_CR: begin
            nxt_char = `PSQ_CHR_CR; // [R21]
            nxt_state = PSQ_ST_LF;
         end
         PSQ_ST_LF: begin
            nxt_char = `PSQ_CHR_LF; // [R21]
            nxt_state = PSQ_ST_IDLE;
         end
         default: begin
            nxt_state = PSQ_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_ff <= PSQ_ST_IDLE;
         seg_ff <= 3'h0;
         seg_end_ff <= 3'h0;
         chr_ff <= 4'h0;
      end else if (query_go || step) begin
         state_ff <= nxt_state;
         seg_ff <= nxt_seg;
         chr_ff <= nxt_chr;
         if (query_go) begin
            seg_end_ff <= q_seg_end;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff <= 8'h00;
      end else if (step) begin
         tx_valid_ff <= 1'b1;
         tx_data_ff <= nxt_char;
      end else if (i_tx_ready) begin
         tx_valid_ff <= 1'b0;
      end
   end

   assign o_tx_valid = tx_valid_ff;
   assign o_tx_data = tx_data_ff;
   assign o_busy = (state_ff != PSQ_ST_IDLE) || tx_valid_ff;
   assign o_unit_active = active_ff;
   assign o_op_flags = op_ff;
   assign o_alarm_flags = alm_ff;
   assign o_error_flags = err_ff;

endmodule : psq_status_engine
`default_nettype wire

// file: test/psq_status_engine_sva.sv
// Port-level checker for the status query engine.
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"
module psq_status_engine_sva
   import psq_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int ANA_CHARS = 5
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Watched inputs.
   input wire logic [ADDR_W-1:0] i_unit_addr,
   input wire logic i_cmd_valid,
   input wire psq_cmd_t i_cmd_code,
   input wire logic [ADDR_W-1:0] i_cmd_addr,
   input wire logic i_regulation_mode,
   input wire logic i_fold_armed,
   input wire logic i_auto_restart,
   input wire logic i_output_on,
   input wire logic i_srq_fold_en,
   input wire logic i_srq_ovp_en,
   input wire logic i_srq_otp_en,
   input wire logic i_ovp_trip,
   input wire logic i_otp_trip,
   input wire logic i_ac_off,
   input wire logic i_fold_trip,
   input wire logic i_fold_cancel,
   input wire logic i_tx_ready,
   // Watched outputs.
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic o_unit_active,
   input wire logic o_busy,
   input wire logic [`PSQ_OP_W-1:0] o_op_flags,
   input wire logic [`PSQ_AL_W-1:0] o_alarm_flags,
   input wire logic [`PSQ_ER_W-1:0] o_error_flags
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire clr_take = i_cmd_valid && i_cmd_code == PSQ_CMD_CLEAR && o_unit_active;
   wire q_take = i_cmd_valid && o_unit_active && !o_busy;

   AST_REGMODE: assert property ($past(i_rst_n) |->
      o_op_flags[0] == $past(i_regulation_mode))
      else $error("regulation mode flag wrong");
   AST_LEVELS: assert property ($past(i_rst_n) |->
      o_op_flags[6:1] == $past({i_srq_otp_en, i_srq_ovp_en, i_srq_fold_en, i_output_on,
      i_auto_restart, i_fold_armed}))
      else $error("operational level flags wrong");
   AST_SUMMARY: assert property (
      o_op_flags[7] == $past(|{o_alarm_flags[4:3], o_alarm_flags[1:0]}))
      else $error("alarm summary wrong");
   AST_FOLD_CANCEL: assert property (i_fold_cancel && !i_fold_trip |=> !o_alarm_flags[3])
      else $error("foldback latch not cleared");
   AST_INPUT_FAIL: assert property (i_ac_off |=> o_alarm_flags[2])
      else $error("input fail not set");
   AST_CMD_FAULT: assert property (|o_error_flags |-> o_alarm_flags[4])
      else $error("command fault not forced");
   AST_ERR_STICKY: assert property (!clr_take |=>
      (o_error_flags & $past(o_error_flags)) == $past(o_error_flags))
      else $error("error bit lost");
   AST_CLEAR: assert property (clr_take && !i_ovp_trip && !i_otp_trip |=>
      o_alarm_flags[1:0] == 2'h0)
      else $error("trip latches not cleared");
   // The sequencer leaves idle at the take edge and loads the first letter one edge later.
   AST_OPER_START: assert property (q_take && i_cmd_code == PSQ_CMD_OPER_Q |->
      ##2 o_tx_valid && o_tx_data == 8'h4F)
      else $error("operational reply did not start");
   AST_CRLF: assert property (o_tx_valid && i_tx_ready && o_tx_data == 8'h0D |=>
      o_tx_valid && o_tx_data == 8'h0A)
      else $error("line feed missing");
   AST_ADDR: assert property (i_cmd_valid && i_cmd_code == PSQ_CMD_ADDR_SEL |=>
      o_unit_active == ($past(i_cmd_addr) == $past(i_unit_addr)))
      else $error("address select wrong");

   COV_OPER: cover property (q_take && i_cmd_code == PSQ_CMD_OPER_Q);
   COV_FULL: cover property (q_take && i_cmd_code == PSQ_CMD_FULL_Q);
   COV_CLEAR: cover property (clr_take);
endmodule : psq_status_engine_sva
bind psq_status_engine psq_status_engine_sva #(.ADDR_W(ADDR_W), .ANA_CHARS(ANA_CHARS)) u_sva (.*);
`default_nettype wire

// file: test/psq_host_sink.sv
// Host-side reply sink that accepts promptly or slowly.
`timescale 1ns/1ps
`default_nettype none
module psq_host_sink (
   // Clock, reset and pacing.
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_slow,
   // Reply stream.
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready
);
   logic [1:0] cnt_ff;
   logic [7:0] got[$];
   // Slow mode is ready one cycle in three, so the engine must hold each character.
   assign o_tx_ready = !i_slow || cnt_ff == 2'h2;
   always @(posedge i_clk) begin
      cnt_ff <= (!i_rst_n || cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      if (i_rst_n && i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
   end
endmodule : psq_host_sink
`default_nettype wire

// file: test/test_psq_status_engine.sv
// Self-checking bench for the status query engine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_psq_status_engine import psq_pkg::*;;
   localparam logic [4:0] MY_ADDR = 5'h14;
   localparam string EOL = "\015\012";
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_cmd_valid = 1'b0, slow = 1'b0, tx_ready;
   psq_cmd_t i_cmd_code = PSQ_CMD_OTHER;
   logic [4:0] i_cmd_addr = 5'h00;
   logic [6:0] lv = 7'h00;
   logic [8:0] ev = 9'h000;
   logic [6:0] pat [2] = '{7'h4D, 7'h32};
   logic o_tx_valid, o_unit_active, o_busy;
   logic [7:0] o_tx_data, o_op_flags;
   logic [4:0] o_alarm_flags, o_error_flags;
   int n_fail = 0, samples_checked = 0;

   psq_status_engine DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_unit_addr(MY_ADDR),
      .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_addr(i_cmd_addr),
      .i_regulation_mode(lv[0]), .i_fold_armed(lv[1]), .i_auto_restart(lv[2]),
      .i_output_on(lv[3]), .i_srq_fold_en(lv[4]), .i_srq_ovp_en(lv[5]), .i_srq_otp_en(lv[6]),
      .i_ovp_trip(ev[0]), .i_otp_trip(ev[1]), .i_ac_off(ev[2]), .i_fold_trip(ev[3]),
      .i_fold_cancel(ev[4]), .i_err_unknown(ev[5]), .i_err_overflow(ev[6]),
      .i_err_volt_range(ev[7]), .i_err_curr_range(ev[8]),
      .i_act_volt(40'h352E303130), .i_set_volt(40'h352E303030),
      .i_act_curr(40'h30302E3030), .i_set_curr(40'h32342E3331),
      .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(tx_ready),
      .o_unit_active(o_unit_active), .o_busy(o_busy), .o_op_flags(o_op_flags),
      .o_alarm_flags(o_alarm_flags), .o_error_flags(o_error_flags));
   psq_host_sink host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
      .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_tx_ready(tx_ready));

   initial begin
      forever #10 i_clk = ~i_clk;
   end

   function automatic string img(logic [7:0] v, int n);
      string s;
      s = "";
      for (int i = 0; i < n; i++) s = {s, v[i] ? "1" : "0"};
      return s;
   endfunction : img

   task automatic cmd(psq_cmd_t c, logic [4:0] a);
      @(posedge i_clk);
      i_cmd_valid <= 1'b1;
      i_cmd_code <= c;
      i_cmd_addr <= a;
      @(posedge i_clk);
      i_cmd_valid <= 1'b0;
   endtask : cmd

   task automatic evt(logic [8:0] m);
      @(posedge i_clk);
      ev <= m;
      @(posedge i_clk);
      ev <= 9'h000;
      repeat (3) @(posedge i_clk);
   endtask : evt

   task automatic query(psq_cmd_t c, string exp);
      int k;
      host.got.delete();
      cmd(c, MY_ADDR);
      k = 0;
      // The next command waits until the whole reply has drained.
      while ((o_busy !== 1'b0 || k < 2) && k < 500) begin
         @(posedge i_clk);
         #1;
         k++;
      end
      `CHK(o_busy, 1'b0)
      `CHK(host.got.size(), exp.len())
      for (k = 0; k < exp.len() && k < host.got.size(); k++) `CHK(host.got[k], exp[k])
   endtask : query

   task automatic tally_and_finish();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // The sequence needs under 400 cycles; fifty times that means a hang.
   initial begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      `CHK({o_unit_active, o_alarm_flags, o_error_flags}, 11'h000)
      cmd(PSQ_CMD_OPER_Q, MY_ADDR);
      repeat (3) @(posedge i_clk);
      #1;
      `CHK({o_busy, o_tx_valid}, 2'h0)
      cmd(PSQ_CMD_ADDR_SEL, 5'h03);
      cmd(PSQ_CMD_ADDR_SEL, MY_ADDR);
      #1;
      `CHK(o_unit_active, 1'b1)
      foreach (pat[i]) begin
         @(posedge i_clk);
         lv <= pat[i];
         query(PSQ_CMD_OPER_Q, {"OS", img({1'b0, pat[i]}, 8), EOL});
      end
      evt(9'h004);
      query(PSQ_CMD_ALARM_Q, {"AL00100", EOL});
      query(PSQ_CMD_OPER_Q, {"OS", img({1'b0, pat[1]}, 8), EOL});
      cmd(PSQ_CMD_CLEAR, 5'h00);
      query(PSQ_CMD_ALARM_Q, {"AL00000", EOL});
      evt(9'h1EB);
      query(PSQ_CMD_ALARM_Q, {"AL11011", EOL});
      query(PSQ_CMD_ERROR_Q, {"PS01111", EOL});
      query(PSQ_CMD_OPER_Q, {"OS", img({1'b1, pat[1]}, 8), EOL});
      `CHK(o_op_flags, {1'b1, pat[1]})
      `CHK(o_error_flags, 5'h1E)
      evt(9'h010);
      evt(9'h004);
      query(PSQ_CMD_ALARM_Q, {"AL00101", EOL});
      query(PSQ_CMD_ERROR_Q, {"PS01111", EOL});
      cmd(PSQ_CMD_CLEAR, 5'h00);
      cmd(PSQ_CMD_OTHER, 5'h00);
      slow <= 1'b1;
      query(PSQ_CMD_FULL_Q, {"AV5.010SV5.000AA00.00SA24.31OS", img({1'b0, pat[1]}, 8),
         "AL00000PS00000", EOL});
      cmd(PSQ_CMD_ADDR_SEL, 5'h07);
      #1;
      `CHK(o_unit_active, 1'b0)
      tally_and_finish();
   end
endmodule : test_psq_status_engine
`default_nettype wire
